//--- core/wmbae_pkg.sv
// Purpose: Shared types and constants of the word move and byte arithmetic execution unit.
// Assumes: Cycle figures are core clock periods with the program in internal ROM.
// Notes:   The fast RAM and external window bounds are parameters of the top module.
package wmbae_pkg;

  typedef enum logic [3:0] {
    WF_RP_IMM, WF_SADDR_IMM, WF_AX_SADDR, WF_SADDR_AX, WF_AX_RP,
    WF_RP_AX, WF_AX_ABS, WF_ABS_AX, WF_SWAP
  } wmbae_wform_t;

  typedef enum logic [3:0] {
    BF_A_IMM, BF_SADDR_IMM, BF_A_R, BF_R_A, BF_A_SADDR, BF_A_ABS,
    BF_A_PTR, BF_A_PTR_DISP, BF_A_PTR_B, BF_A_PTR_C
  } wmbae_bform_t;

  typedef enum logic [2:0] {FN_ADD, FN_ADD_WITH_CARRY_IN, FN_SUB, FN_SUBTRACT_WITH_BORROW, FN_AND} wmbae_fn_t;

  // Byte register indices; pair k holds register 2k low and 2k+1 high.
  localparam logic [2:0] RI_A  = 3'h1;
  localparam logic [2:0] RI_C  = 3'h2;
  localparam logic [2:0] RI_B  = 3'h3;
  localparam logic [2:0] RI_L  = 3'h6;
  localparam logic [2:0] RI_H  = 3'h7;
  localparam logic [1:0] RP_AX = 2'h0;

  // Base cycle counts: _F for fast RAM or no data access, _S for any other area.
  localparam logic [5:0] CYC_W_IMM_REG    = 6'h06;
  localparam logic [5:0] CYC_W_SADDR_IMM_F = 6'h08;
  localparam logic [5:0] CYC_W_SADDR_IMM_S = 6'h0A;
  localparam logic [5:0] CYC_W_SADDR_F    = 6'h06;
  localparam logic [5:0] CYC_W_SADDR_S    = 6'h08;
  localparam logic [5:0] CYC_W_REG        = 6'h04;
  localparam logic [5:0] CYC_W_ABS_F      = 6'h0A;
  localparam logic [5:0] CYC_W_ABS_S      = 6'h0C;
  localparam logic [5:0] CYC_B_IMM        = 6'h04;
  localparam logic [5:0] CYC_B_SADDR_IMM_F = 6'h06;
  localparam logic [5:0] CYC_B_SADDR_IMM_S = 6'h08;
  localparam logic [5:0] CYC_B_SADDR_F    = 6'h04;
  localparam logic [5:0] CYC_B_SADDR_S    = 6'h05;
  localparam logic [5:0] CYC_B_ABS_F      = 6'h08;
  localparam logic [5:0] CYC_B_ABS_S      = 6'h09;
  localparam logic [5:0] CYC_B_PTR_F      = 6'h04;
  localparam logic [5:0] CYC_B_PTR_S      = 6'h05;
  localparam logic [5:0] CYC_B_IDX_F      = 6'h08;
  localparam logic [5:0] CYC_B_IDX_S      = 6'h09;

  // Instruction lengths in bytes.
  localparam logic [2:0] LEN_W_IMM_REG    = 3'h3;
  localparam logic [2:0] LEN_W_SADDR_IMM  = 3'h4;
  localparam logic [2:0] LEN_W_SADDR      = 3'h2;
  localparam logic [2:0] LEN_W_REG        = 3'h1;
  localparam logic [2:0] LEN_W_ABS        = 3'h3;
  localparam logic [2:0] LEN_B_IMM        = 3'h2;
  localparam logic [2:0] LEN_B_SADDR_IMM  = 3'h3;
  localparam logic [2:0] LEN_B_REG        = 3'h2;
  localparam logic [2:0] LEN_B_ABS        = 3'h3;
  localparam logic [2:0] LEN_B_PTR        = 3'h1;
  localparam logic [2:0] LEN_B_IDX        = 3'h2;

  // Default memory windows.
  localparam logic [15:0] FAST_LO_DEF = 16'hFC00;
  localparam logic [15:0] FAST_HI_DEF = 16'hFEFF;
  localparam logic [15:0] EXT_LO_DEF  = 16'h8000;
  localparam logic [15:0] EXT_HI_DEF  = 16'hEFFF;

endpackage : wmbae_pkg

//--- core/wmbae_byte_alu.sv
// Purpose: Byte adder, subtracter and AND with zero, half-carry and carry outputs.
// Assumes: Purely combinational; the caller decides which flags are stored.
// Notes:   Carry-in is used only by the with-carry and with-borrow functions.
`timescale 1ns/1ps
module wmbae_byte_alu
  import wmbae_pkg::*;
(
  // Operation
  input  wire wmbae_fn_t  fn,
  input  wire logic [7:0] opa,
  input  wire logic [7:0] opb,
  input  wire logic       cy_in,
  // Result
  output logic [7:0]      res,
  output logic            z,
  output logic            ac,
  output logic            cy
);
  logic       ci;
  logic [4:0] lo;
  logic [8:0] full;

  always_comb begin
    ci   = ((fn == FN_ADD_WITH_CARRY_IN) || (fn == FN_SUBTRACT_WITH_BORROW)) && cy_in;
    lo   = 5'h00;
    full = 9'h000;
    unique case (fn)
      FN_ADD, FN_ADD_WITH_CARRY_IN: begin
        lo   = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, ci};
        full = {1'b0, opa} + {1'b0, opb} + {8'h00, ci};
      end
      FN_SUB, FN_SUBTRACT_WITH_BORROW: begin
        lo   = {1'b0, opa[3:0]} - {1'b0, opb[3:0]} - {4'h0, ci};
        full = {1'b0, opa} - {1'b0, opb} - {8'h00, ci};
      end
      default: full = {1'b0, opa & opb};
    endcase
    res = full[7:0];
    z   = (full[7:0] == 8'h00);
    ac  = lo[4];
    cy  = full[8];
  end
endmodule : wmbae_byte_alu

//--- core/wmbae_exec.sv
// Purpose: Execution unit for 16-bit moves, word swap and byte add, sub and AND.
// Assumes: Decoded instruction fields arrive with start; program runs from internal ROM.
// Notes:   Memory returns read data in the same clock as a read request.
// Notes on behaviour
// - Cycle counts are counted in core clock periods chosen by the clock select.
// - Access outside fast RAM uses the second, longer cycle count.
// - Fast RAM access, or no data access, uses the first cycle count.
// - Figures assume program fetch from internal ROM; other fetches not modelled.
// - External area adds n waits per read and m waits per write.
// - Word immediate to short-direct: 4 bytes, 8 or 10 cycles.
// - Word load from absolute location: 3 bytes, 10 or 12+2n cycles.
// - Word store to absolute location: 3 bytes, 10 or 12+2m cycles.
// - Accumulator-pair transfers with another pair allow only the three other pairs.
// - Immediate add into short-direct writes back and updates carry; 3 bytes, 6/8.
// - Indexed add fetches pointer plus register operand, updates Z, AC, CY.
// - Add-with-carry adds operand and old carry; immediate form 2 bytes, 4 cycles.
// - Pointer-plus-offset subtract sets carry from borrow; 2 bytes, 8 or 9+n.
// - Subtract-with-borrow on short-direct stores result, updates Z, AC, CY.
// - AND updates only zero; immediate form 2 bytes, 4 cycles.
// - AND into short-direct reads, combines, writes back; 6 or 8 cycles.
// - Affected flags follow the result; other flags keep their value.
`timescale 1ns/1ps
module wmbae_exec
  import wmbae_pkg::*;
#(
  parameter logic [15:0] FAST_LO = FAST_LO_DEF,
  parameter logic [15:0] FAST_HI = FAST_HI_DEF,
  parameter logic [15:0] EXT_LO  = EXT_LO_DEF,
  parameter logic [15:0] EXT_HI  = EXT_HI_DEF
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Configuration
  input  wire logic [1:0]   core_clock_select_reg,
  input  wire logic [3:0]   read_waits,
  input  wire logic [3:0]   write_waits,
  // Instruction
  input  wire logic         start,
  input  wire logic         ins_word,
  input  wire wmbae_wform_t ins_wform,
  input  wire wmbae_bform_t ins_bform,
  input  wire wmbae_fn_t    ins_fn,
  input  wire logic [2:0]   ins_reg,
  input  wire logic [15:0]  ins_addr,
  input  wire logic [15:0]  ins_imm,
  // Status
  output logic              busy_q,
  output logic              done_q,
  output logic              err_q,
  output logic [2:0]        len_q,
  output logic [5:0]        tot_q,
  output logic [63:0]       reg_bank_q,
  output logic              z_q,
  output logic              ac_q,
  output logic              cy_q,
  // Memory
  input  wire logic [7:0]   mem_rdata,
  output logic              mem_req_q,
  output logic              mem_we_q,
  output logic [15:0]       mem_addr_q,
  output logic [7:0]        mem_wdata_q
);
  typedef enum logic [2:0] {S_IDLE, S_RD, S_CAP, S_EXEC, S_WR, S_HOLD} wmbae_state_t;

  localparam int DONE_MAX = 400;

  // Core clock enable divider.
  logic [2:0] div_q, div_d;
  logic       core_en;
  always_comb begin
    div_d   = div_q + 3'h1;
    core_en = ((div_q & 3'((4'h1 << core_clock_select_reg) - 4'h1)) == 3'h0);
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) div_q <= 3'h0;
    else div_q <= div_d;
  end

  // Decode of the incoming instruction.
  logic [7:0][7:0] regs_q, regs_d;
  logic [15:0] hl, ea_c;
  logic [5:0]  b1_c, b2_c, tot_c;
  logic [2:0]  len_c;
  logic [1:0]  rd_c, wr_c;
  logic        slow_c, ext_c, illegal_c;

  always_comb begin
    hl     = {regs_q[RI_H], regs_q[RI_L]};
    ea_c   = ins_addr;
    rd_c = 2'h0; wr_c = 2'h0; len_c = LEN_W_REG; b1_c = CYC_W_REG; b2_c = CYC_W_REG;
    illegal_c = 1'b0;
    if (ins_word) begin
      unique case (ins_wform)
        WF_RP_IMM: begin len_c = LEN_W_IMM_REG; b1_c = CYC_W_IMM_REG; b2_c = CYC_W_IMM_REG; end
        WF_SADDR_IMM: begin
          len_c = LEN_W_SADDR_IMM; b1_c = CYC_W_SADDR_IMM_F; b2_c = CYC_W_SADDR_IMM_S;
          wr_c = 2'h2;
        end
        WF_AX_SADDR, WF_SADDR_AX: begin
          len_c = LEN_W_SADDR; b1_c = CYC_W_SADDR_F; b2_c = CYC_W_SADDR_S;
          if (ins_wform == WF_AX_SADDR) rd_c = 2'h2;
          else wr_c = 2'h2;
        end
        WF_AX_ABS, WF_ABS_AX: begin
          len_c = LEN_W_ABS; b1_c = CYC_W_ABS_F; b2_c = CYC_W_ABS_S;
          if (ins_wform == WF_AX_ABS) rd_c = 2'h2;
          else wr_c = 2'h2;
        end
        default: illegal_c = (ins_reg[1:0] == RP_AX);
      endcase
    end else begin
      len_c = LEN_B_IDX; b1_c = CYC_B_IDX_F; b2_c = CYC_B_IDX_S; rd_c = 2'h1;
      unique case (ins_bform)
        BF_A_IMM: begin len_c = LEN_B_IMM; b1_c = CYC_B_IMM; b2_c = CYC_B_IMM; rd_c = 2'h0; end
        BF_SADDR_IMM: begin
          len_c = LEN_B_SADDR_IMM; b1_c = CYC_B_SADDR_IMM_F; b2_c = CYC_B_SADDR_IMM_S;
          wr_c = 2'h1;
        end
        BF_A_R, BF_R_A: begin len_c = LEN_B_REG; b1_c = CYC_B_IMM; b2_c = CYC_B_IMM; rd_c = 2'h0; end
        BF_A_SADDR: begin len_c = LEN_B_REG; b1_c = CYC_B_SADDR_F; b2_c = CYC_B_SADDR_S; end
        BF_A_ABS: begin len_c = LEN_B_ABS; b1_c = CYC_B_ABS_F; b2_c = CYC_B_ABS_S; end
        BF_A_PTR: begin len_c = LEN_B_PTR; b1_c = CYC_B_PTR_F; b2_c = CYC_B_PTR_S; ea_c = hl; end
        BF_A_PTR_DISP: ea_c = hl + {8'h00, ins_imm[7:0]};
        BF_A_PTR_B: ea_c = hl + {8'h00, regs_q[RI_B]};
        default: ea_c = hl + {8'h00, regs_q[RI_C]};
      endcase
    end
    ext_c  = (ea_c >= EXT_LO) && (ea_c <= EXT_HI) && ((rd_c | wr_c) != 2'h0);
    slow_c = !((ea_c >= FAST_LO) && (ea_c <= FAST_HI)) && ((rd_c | wr_c) != 2'h0);
    tot_c  = (slow_c ? b2_c : b1_c);
    if (ext_c) begin
      // Widen before multiplying so that 2 x 15 waits cannot wrap in four bits.
      tot_c = tot_c + ({2'h0, read_waits} * {4'h0, rd_c})
                    + ({2'h0, write_waits} * {4'h0, wr_c});
    end
  end

  // Execution state.
  wmbae_state_t state_q, state_d;
  logic         word_q, word_d;
  wmbae_wform_t wform_q, wform_d;
  wmbae_bform_t bform_q, bform_d;
  wmbae_fn_t    fn_q, fn_d;
  logic [2:0]   reg_q, reg_d, len_d;
  logic [15:0]  imm_q, imm_d, ea_q, ea_d, opnd_q, opnd_d;
  logic [1:0]   rd_q, rd_d, wr_q, wr_d;
  logic         bi_q, bi_d;
  logic [5:0]   cnt_q, cnt_d, tot_d;
  logic         busy_d, done_d, err_d, z_d, ac_d, cy_d, req_d, we_d;
  logic [15:0]  maddr_d;
  logic [7:0]   wdata_d, alu_a, alu_b, alu_res, out_byte;
  logic         alu_z, alu_ac, alu_cy;
  logic [2:0]   rsel, plo, phi;

  wmbae_byte_alu u_alu (
    .fn    (fn_q),
    .opa   (alu_a),
    .opb   (alu_b),
    .cy_in (cy_q),
    .res   (alu_res),
    .z     (alu_z),
    .ac    (alu_ac),
    .cy    (alu_cy)
  );

  always_comb begin
    rsel  = reg_q;
    plo   = {reg_q[1:0], 1'b0};
    phi   = {reg_q[1:0], 1'b1};
    alu_a = regs_q[RI_A];
    alu_b = opnd_q[7:0];
    unique case (bform_q)
      BF_A_IMM: alu_b = imm_q[7:0];
      BF_SADDR_IMM: begin alu_a = opnd_q[7:0]; alu_b = imm_q[7:0]; end
      BF_A_R: alu_b = regs_q[rsel];
      BF_R_A: begin alu_a = regs_q[rsel]; alu_b = regs_q[RI_A]; end
      default: alu_b = opnd_q[7:0];
    endcase
  end

  always_comb begin
    state_d = state_q; word_d = word_q; wform_d = wform_q; bform_d = bform_q; fn_d = fn_q;
    reg_d = reg_q; imm_d = imm_q; ea_d = ea_q; opnd_d = opnd_q; rd_d = rd_q; wr_d = wr_q;
    bi_d = bi_q; tot_d = tot_q; len_d = len_q; regs_d = regs_q;
    z_d = z_q; ac_d = ac_q; cy_d = cy_q; wdata_d = mem_wdata_q; maddr_d = mem_addr_q;
    req_d = 1'b0; we_d = 1'b0; done_d = 1'b0; err_d = 1'b0;
    cnt_d = (state_q != S_IDLE && core_en) ? cnt_q + 6'h01 : cnt_q;
    out_byte = opnd_q[15:8];
    unique case (state_q)
      S_IDLE: if (start) begin
        if (illegal_c) err_d = 1'b1;
        else begin
          word_d = ins_word; wform_d = ins_wform; bform_d = ins_bform; fn_d = ins_fn;
          reg_d = ins_reg; imm_d = ins_imm; ea_d = ea_c; rd_d = rd_c; wr_d = wr_c;
          tot_d = tot_c; len_d = len_c; cnt_d = 6'h00; bi_d = 1'b0;
          state_d = (rd_c != 2'h0) ? S_RD : S_EXEC;
        end
      end
      S_RD: begin
        req_d = 1'b1; maddr_d = ea_q + {15'h0000, bi_q}; state_d = S_CAP;
      end
      S_CAP: begin
        if (bi_q) opnd_d[15:8] = mem_rdata;
        else opnd_d[7:0] = mem_rdata;
        bi_d = 1'b1;
        state_d = (!bi_q && rd_q == 2'h2) ? S_RD : S_EXEC;
      end
      S_EXEC: begin
        bi_d = 1'b0;
        state_d = (wr_q != 2'h0) ? S_WR : S_HOLD;
        if (word_q) begin
          unique case (wform_q) // flags untouched by all word forms
            WF_RP_IMM: begin regs_d[phi] = imm_q[15:8]; regs_d[plo] = imm_q[7:0]; end
            WF_SADDR_IMM: opnd_d = imm_q;
            WF_AX_SADDR, WF_AX_ABS: begin regs_d[RI_A] = opnd_q[15:8]; regs_d[0] = opnd_q[7:0]; end
            WF_SADDR_AX, WF_ABS_AX: opnd_d = {regs_q[RI_A], regs_q[0]};
            WF_AX_RP: begin regs_d[RI_A] = regs_q[phi]; regs_d[0] = regs_q[plo]; end
            WF_RP_AX: begin regs_d[phi] = regs_q[RI_A]; regs_d[plo] = regs_q[0]; end
            default: begin
              regs_d[RI_A] = regs_q[phi]; regs_d[0] = regs_q[plo];
              regs_d[phi] = regs_q[RI_A]; regs_d[plo] = regs_q[0];
            end
          endcase
        end else begin
          z_d = alu_z;
          if (fn_q != FN_AND) begin
            ac_d = alu_ac;
            cy_d = alu_cy;
          end
          if (bform_q == BF_SADDR_IMM) opnd_d = {8'h00, alu_res};
          else if (bform_q == BF_R_A) regs_d[rsel] = alu_res;
          else regs_d[RI_A] = alu_res;
        end
      end
      S_WR: begin
        req_d = 1'b1; we_d = 1'b1; maddr_d = ea_q + {15'h0000, bi_q};
        wdata_d = bi_q ? out_byte : opnd_q[7:0];
        bi_d = 1'b1;
        state_d = (!bi_q && wr_q == 2'h2) ? S_WR : S_HOLD;
      end
      default: if (cnt_q >= tot_q) begin
        done_d = 1'b1; state_d = S_IDLE;
      end
    endcase
    busy_d = (state_d != S_IDLE);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= S_IDLE; word_q <= 1'b0; wform_q <= WF_RP_IMM; bform_q <= BF_A_IMM;
      fn_q <= FN_ADD; reg_q <= 3'h0; imm_q <= 16'h0000; ea_q <= 16'h0000;
      opnd_q <= 16'h0000; rd_q <= 2'h0; wr_q <= 2'h0; bi_q <= 1'b0; cnt_q <= 6'h00;
      tot_q <= 6'h00; len_q <= 3'h0; regs_q <= '0; z_q <= 1'b0; ac_q <= 1'b0;
      cy_q <= 1'b0; busy_q <= 1'b0; done_q <= 1'b0; err_q <= 1'b0; mem_req_q <= 1'b0;
      mem_we_q <= 1'b0; mem_addr_q <= 16'h0000; mem_wdata_q <= 8'h00;
    end else begin
      state_q <= state_d; word_q <= word_d; wform_q <= wform_d; bform_q <= bform_d;
      fn_q <= fn_d; reg_q <= reg_d; imm_q <= imm_d; ea_q <= ea_d; opnd_q <= opnd_d;
      rd_q <= rd_d; wr_q <= wr_d; bi_q <= bi_d; cnt_q <= cnt_d; tot_q <= tot_d;
      len_q <= len_d; regs_q <= regs_d; z_q <= z_d; ac_q <= ac_d; cy_q <= cy_d;
      busy_q <= busy_d; done_q <= done_d; err_q <= err_d; mem_req_q <= req_d;
      mem_we_q <= we_d; mem_addr_q <= maddr_d; mem_wdata_q <= wdata_d;
    end
  end

  assign reg_bank_q = regs_q;

  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_take;
    state_q == S_IDLE && start && !illegal_c;
  endsequence
  sequence s_finish;
    done_q && state_q == S_IDLE;
  endsequence

  core_count_a: assert property (state_q != S_IDLE && !core_en |=> $stable(cnt_q))
    else $error("cycle count moved without a core clock enable");
  slow_base_a: assert property (s_take and (!ins_word && ins_bform == BF_A_SADDR
      && slow_c) |=> tot_q == CYC_B_SADDR_S) else $error("slow area count wrong");
  fast_base_a: assert property (s_take and (!ins_word && ins_bform == BF_A_IMM)
      |=> tot_q == CYC_B_IMM && len_q == LEN_B_IMM) else $error("no access count wrong");
  word_saddr_a: assert property (s_take and (ins_word && ins_wform == WF_SADDR_IMM
      && !slow_c) |=> tot_q == CYC_W_SADDR_IMM_F && len_q == LEN_W_SADDR_IMM)
    else $error("word imm count");
  abs_load_a: assert property (s_take and (ins_word && ins_wform == WF_AX_ABS
      && ext_c) |=> tot_q == CYC_W_ABS_S + 6'(2 * $past(read_waits)))
    else $error("word load count");
  abs_store_a: assert property (s_take and (ins_word && ins_wform == WF_ABS_AX
      && ext_c) |=> tot_q == CYC_W_ABS_S + 6'(2 * $past(write_waits)))
    else $error("word store count");
  swap_flags_a: assert property (state_q == S_EXEC && word_q
      |=> $stable(z_q) && $stable(ac_q) && $stable(cy_q)) else $error("word op changed flags");
  pair_legal_a: assert property (state_q == S_IDLE && start && illegal_c
      |=> err_q && state_q == S_IDLE) else $error("accumulator pair with itself accepted");
  and_flags_a: assert property (state_q == S_EXEC && !word_q && fn_q == FN_AND
      |=> $stable(ac_q) && $stable(cy_q)) else $error("AND touched carry flags");
  finish_a: assert property (s_take |-> ##[1:DONE_MAX] s_finish)
    else $error("instruction did not finish");
  finish_count_a: assert property (done_q |-> cnt_q >= tot_q)
    else $error("instruction finished early");

endmodule : wmbae_exec

//--- dv/wmbae_mem_model.sv
// Purpose: Behavioural byte memory on the far side of the execution unit.
// Assumes: Read data stands while a read request does and is taken at the next edge.
// Notes:   Outside a read the data toggles each clock, so a stale byte never passes.
`timescale 1ns/1ps
module wmbae_mem_model (
  // Clock
  input  wire logic        clk,
  // Request
  input  wire logic        mem_req_q,
  input  wire logic        mem_we_q,
  input  wire logic [15:0] mem_addr_q,
  input  wire logic [7:0]  mem_wdata_q,
  // Answer
  output logic [7:0]       mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] idle_q;
  initial idle_q = 8'h5A;
  // Every byte is its own request, so a word costs two of them.
  always @(posedge clk) begin
    if (mem_req_q && mem_we_q) begin
      mem[mem_addr_q] <= mem_wdata_q;
    end
    idle_q <= ~idle_q;
  end
  // The unit captures the byte at the edge that ends its request cycle.
  assign mem_rdata = (mem_req_q && !mem_we_q) ? mem[mem_addr_q] : idle_q;
endmodule : wmbae_mem_model

//--- dv/word_move_and_byte_arith_exec_tb.sv
// Purpose: Self-checking bench for the word move and byte arithmetic unit.
// Assumes: Fast RAM FC00..FEFF, external window 8000..EFFF (defaults).
// Notes:   Scenarios run in order; several leave state that later ones use.
`timescale 1ns/1ps
module word_move_and_byte_arith_exec_tb
  import wmbae_pkg::*;
;
  logic         clk;
  logic         rst_b;
  logic [1:0]   sel;
  logic [3:0]   rw;
  logic [3:0]   ww;
  logic         start;
  logic         iw;
  wmbae_wform_t wf;
  wmbae_bform_t bf;
  wmbae_fn_t    fn;
  logic [2:0]   ir;
  logic [15:0]  ia;
  logic [15:0]  im;
  logic         busy_q, done_q, err_q, z_q, ac_q, cy_q;
  logic         mem_req_q, mem_we_q;
  logic [2:0]   len_q;
  logic [5:0]   tot_q;
  logic [63:0]  rb;
  logic [15:0]  mem_addr_q;
  logic [7:0]   mem_wdata_q, mem_rdata;
  int           err_count, cmp_count, n_clk;

  wmbae_exec uut (.clk(clk), .rst_b(rst_b), .core_clock_select_reg(sel), .read_waits(rw),
    .write_waits(ww), .start(start), .ins_word(iw), .ins_wform(wf), .ins_bform(bf),
    .ins_fn(fn), .ins_reg(ir), .ins_addr(ia), .ins_imm(im), .busy_q(busy_q),
    .done_q(done_q), .err_q(err_q), .len_q(len_q), .tot_q(tot_q), .reg_bank_q(rb),
    .z_q(z_q), .ac_q(ac_q), .cy_q(cy_q), .mem_rdata(mem_rdata), .mem_req_q(mem_req_q),
    .mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q));
  wmbae_mem_model mem_i (.clk(clk), .mem_req_q(mem_req_q), .mem_we_q(mem_we_q),
    .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q), .mem_rdata(mem_rdata));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask : chk

  // Issues one instruction and waits for done or refusal; n_clk counts clocks from take.
  task automatic run(input logic w, input wmbae_wform_t f, input wmbae_bform_t b,
                     input wmbae_fn_t op, input logic [2:0] r, input logic [15:0] a,
                     input logic [15:0] v);
    @(posedge clk);
    start <= 1'b1; iw <= w; wf <= f; bf <= b; fn <= op; ir <= r; ia <= a; im <= v;
    @(posedge clk);
    start <= 1'b0;
    n_clk = 1;
    @(negedge clk);
    chk("busy", 16'(!err_q), 16'(busy_q));
    while (done_q !== 1'b1 && err_q !== 1'b1 && n_clk < 400) begin
      @(negedge clk);
      n_clk++;
    end
    chk("answer", 16'h0001, 16'(n_clk < 400));
    chk("idle", 16'h0000, 16'(busy_q));
  endtask : run

  task automatic setp(input logic [2:0] r, input logic [15:0] v);
    run(1'b1, WF_RP_IMM, BF_A_IMM, FN_ADD, r, 16'h0000, v);
    chk("rp imm tot", 16'h0006, tot_q);
  endtask : setp

  task automatic t_word_saddr;
    run(1'b1, WF_SADDR_IMM, BF_A_IMM, FN_ADD, 3'h0, 16'hFE20, 16'hBEEF);
    chk("wsaddr len", 16'h0004, len_q);
    chk("wsaddr tot", 16'h0008, tot_q);
    chk("low byte", 16'h00EF, mem_i.mem[16'hFE20]);
    chk("high byte", 16'h00BE, mem_i.mem[16'hFE21]);
    run(1'b1, WF_SADDR_IMM, BF_A_IMM, FN_ADD, 3'h0, 16'hFF00, 16'h1357);
    chk("wsaddr slow tot", 16'h000A, tot_q);
  endtask : t_word_saddr

  task automatic t_word_abs;
    @(posedge clk);
    rw <= 4'h2;
    ww <= 4'h3;
    run(1'b1, WF_AX_ABS, BF_A_IMM, FN_ADD, 3'h0, 16'h8000, 16'h0000);
    chk("load ax", 16'h1234, rb[15:0]);
    chk("load tot", 16'h0010, tot_q);
    chk("load len", 16'h0003, len_q);
    run(1'b1, WF_ABS_AX, BF_A_IMM, FN_ADD, 3'h0, 16'h8010, 16'h0000);
    chk("store tot", 16'h0012, tot_q);
    chk("store bytes", 16'h1234, {mem_i.mem[16'h8011], mem_i.mem[16'h8010]});
  endtask : t_word_abs

  task automatic t_add_saddr;
    run(1'b0, WF_RP_IMM, BF_SADDR_IMM, FN_ADD, 3'h0, 16'hFE30, 16'h0020);
    chk("add saddr", 16'h0010, mem_i.mem[16'hFE30]);
    chk("add flags", 16'h0001, {z_q, ac_q, cy_q});
    chk("add tot", 16'h0006, tot_q);
  endtask : t_add_saddr

  task automatic t_swap;
    wmbae_wform_t bad [3];
    bad = '{WF_AX_RP, WF_RP_AX, WF_SWAP};
    setp(3'h1, 16'h0305);
    run(1'b1, WF_SWAP, BF_A_IMM, FN_ADD, 3'h1, 16'h0000, 16'h0000);
    chk("swap ax", 16'h0305, rb[15:0]);
    chk("swap bc", 16'h1234, rb[31:16]);
    chk("swap cost", 16'h0104, {5'h00, len_q, 2'h0, tot_q});
    chk("swap flags", 16'h0001, {z_q, ac_q, cy_q});
    foreach (bad[i]) begin
      run(1'b1, bad[i], BF_A_IMM, FN_ADD, 3'h0, 16'h0000, 16'h0000);
      chk("refused", 16'h0001, {done_q, err_q});
    end
    chk("ax kept", 16'h0305, rb[15:0]);
    run(1'b1, WF_RP_AX, BF_A_IMM, FN_ADD, 3'h2, 16'h0000, 16'h0000);
    chk("rp ax", 16'h0305, rb[47:32]);
    chk("rp ax cost", 16'h0104, {5'h00, len_q, 2'h0, tot_q});
  endtask : t_swap

  task automatic t_add_with_carry_in_and;
    run(1'b0, WF_RP_IMM, BF_A_IMM, FN_ADD_WITH_CARRY_IN, 3'h0, 16'h0000, 16'h000C);
    chk("add_with_carry_in a", 16'h0010, rb[15:8]);
    chk("add_with_carry_in flags", 16'h0002, {z_q, ac_q, cy_q});
    chk("add_with_carry_in cost", 16'h0204, {5'h00, len_q, 2'h0, tot_q});
    run(1'b0, WF_RP_IMM, BF_A_IMM, FN_AND, 3'h0, 16'h0000, 16'h000F);
    chk("and a", 16'h0000, rb[15:8]);
    chk("and flags", 16'h0006, {z_q, ac_q, cy_q});
    chk("and cost", 16'h0204, {5'h00, len_q, 2'h0, tot_q});
  endtask : t_add_with_carry_in_and

  task automatic t_and_saddr;
    run(1'b0, WF_RP_IMM, BF_SADDR_IMM, FN_AND, 3'h0, 16'hFF00, 16'h000F);
    chk("and saddr", 16'h0007, mem_i.mem[16'hFF00]);
    chk("and saddr tot", 16'h0008, tot_q);
    run(1'b0, WF_RP_IMM, BF_A_SADDR, FN_ADD, 3'h0, 16'hFF01, 16'h0000);
    chk("add a saddr", 16'h0013, rb[15:8]);
    chk("add a saddr cost", 16'h0205, {5'h00, len_q, 2'h0, tot_q});
  endtask : t_and_saddr

  task automatic t_sub_ptr;
    setp(3'h3, 16'h8000);
    setp(3'h0, 16'h1000);
    run(1'b0, WF_RP_IMM, BF_A_PTR_DISP, FN_SUB, 3'h0, 16'h0000, 16'h0005);
    chk("sub a", 16'h00F0, rb[15:8]);
    chk("sub flags", 16'h0001, {z_q, ac_q, cy_q});
    chk("sub cost", 16'h020B, {5'h00, len_q, 2'h0, tot_q});
    run(1'b0, WF_RP_IMM, BF_A_PTR_B, FN_ADD, 3'h3, 16'h0000, 16'h0000);
    chk("idx a", 16'h0000, rb[15:8]);
    chk("idx flags", 16'h0005, {z_q, ac_q, cy_q});
    chk("idx tot", 16'h000B, tot_q);
  endtask : t_sub_ptr

  task automatic t_subtract_with_borrow;
    run(1'b0, WF_RP_IMM, BF_SADDR_IMM, FN_SUBTRACT_WITH_BORROW, 3'h0, 16'hFE40, 16'h000F);
    chk("subtract_with_borrow saddr", 16'h0000, mem_i.mem[16'hFE40]);
    chk("subtract_with_borrow flags", 16'h0006, {z_q, ac_q, cy_q});
    chk("subtract_with_borrow tot", 16'h0006, tot_q);
  endtask : t_subtract_with_borrow

  task automatic t_clk_sel;
    @(posedge clk);
    sel <= 2'h3;
    run(1'b0, WF_RP_IMM, BF_A_IMM, FN_ADD, 3'h0, 16'h0000, 16'h0001);
    // Four core cycles of eight clocks each plus two to finish, less up to seven for the divider phase.
    chk("slow core clock", 16'h0001, 16'(n_clk >= 27 && n_clk <= 34));
    @(posedge clk);
    sel <= 2'h0;
  endtask : t_clk_sel

  initial begin
    repeat (5000) @(posedge clk);
    $display("MISMATCH watchdog expected 0 seen 1");
    err_count++;
    close_out();
  end

  initial begin
    err_count = 0;
    cmp_count = 0;
    rst_b = 1'b0; sel = 2'h0; rw = 4'h0; ww = 4'h0; start = 1'b0; iw = 1'b0;
    wf = WF_RP_IMM; bf = BF_A_IMM; fn = FN_ADD; ir = 3'h0; ia = 16'h0000; im = 16'h0000;
    mem_i.mem[16'h8000] = 8'h34; mem_i.mem[16'h8001] = 8'h12; mem_i.mem[16'hFE30] = 8'hF0;
    mem_i.mem[16'h8005] = 8'h20; mem_i.mem[16'h8012] = 8'h10; mem_i.mem[16'hFE40] = 8'h10;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_word_saddr();
    t_word_abs();
    t_add_saddr();
    t_swap();
    t_add_with_carry_in_and();
    t_and_saddr();
    t_sub_ptr();
    t_subtract_with_borrow();
    t_clk_sel();
    close_out();
  end
endmodule : word_move_and_byte_arith_exec_tb
